// File: bench/mbrw_link_chk.sv
// link checker for the read/write register link
`timescale 1ns/1ps
module mbrw_link_chk (
    // clock, reset and link
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] q_data,
    input wire logic       q_valid,
    input wire logic       q_last,
    input wire logic [7:0] r_data,
    input wire logic       r_valid,
    input wire logic       r_last
);
    // ====
    // byte positions and captured query and reply fields
    logic [5:0] qi_q, ri_q;
    logic [7:0] qa_q, qf_q, qc_q, bc_q;
    logic       ex_q;
    always_ff @(posedge clk) begin
        qi_q <= (rst || (q_valid && q_last)) ? 6'h00 : qi_q + 6'(q_valid);
        ri_q <= (rst || (r_valid && r_last)) ? 6'h00 : ri_q + 6'(r_valid);
        if (q_valid && qi_q == 6'h00) qa_q <= q_data;
        if (q_valid && qi_q == 6'h01) qf_q <= q_data;
        if (q_valid && qi_q == 6'h05) qc_q <= q_data;
        if (r_valid && ri_q == 6'h01) ex_q <= r_data[7];
        if (r_valid && ri_q == 6'h02) bc_q <= r_data;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_back; r_valid && !r_last |=> r_valid; endproperty
    a_back: assert property (p_back) else $error("reply gap");
    property p_gap; q_valid && q_last |=> !r_valid; endproperty
    a_gap: assert property (p_gap) else $error("reply too early");
    property p_addr; r_valid && ri_q == 6'h00 |-> r_data == qa_q; endproperty
    a_addr: assert property (p_addr) else $error("reply address");
    property p_func;
        r_valid && ri_q == 6'h01 |-> r_data == qf_q || r_data == (qf_q | 8'h80);
    endproperty
    a_func: assert property (p_func) else $error("reply function");
    property p_exlen;
        r_valid && ri_q == 6'h01 && r_data[7] |=> (r_valid && !r_last) [*2] ##1 r_last;
    endproperty
    a_exlen: assert property (p_exlen) else $error("exception length");
    property p_bc; r_valid && ri_q == 6'h02 && !ex_q |-> r_data == {qc_q[6:0], 1'b0}; endproperty
    a_bc: assert property (p_bc) else $error("byte count");
    property p_nlen; r_valid && r_last && !ex_q |-> ri_q == bc_q[5:0] + 6'h04; endproperty
    a_nlen: assert property (p_nlen) else $error("reply length");
    property p_big; r_valid && ri_q == 6'h02 && qc_q > 8'h10 |-> ex_q && r_data == 8'h03; endproperty
    a_big: assert property (p_big) else $error("count limit");
    property p_bcast; q_valid && q_last && qa_q == 8'h00 |=> !r_valid [*8]; endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast answered");
    c_norm: cover property (r_valid && r_last && !ex_q);
    c_exc: cover property (r_valid && ri_q == 6'h02 && ex_q);
    c_bcast: cover property (q_valid && q_last && qa_q == 8'h00);
endmodule

// File: bench/modbus_rw_multi_responder_tb_top.sv
// testbench: master and device joined over the byte link
`timescale 1ns/1ps
module modbus_rw_multi_responder_tb_top import mbrw_pkg::*;;
    // ====
    // stimulus and observed signals
    logic         clk = 1'b0, rst = 1'b1, req_valid = 1'b0;
    logic [7:0]   req_unit = 8'h01;
    logic [15:0]  req_rd_reg = '0, req_wr_reg = '0;
    logic [4:0]   req_rd_cnt = '0, req_wr_cnt = '0;
    logic [255:0] req_wr_data = '0;
    logic         busy, done, ok, timeout, reg_wr_pulse, frame_drop;
    logic [7:0]   exc_code;
    logic [255:0] rd_data;
    logic [15:0]  reg_wr_num, reg_wr_val;
    int           n_mismatch = 0;
    int           comparisons = 0;
    int           n_pulse = 0;
    mbrw_link_if link ();
    always #10 clk = ~clk;
    // drops weigh 256 each, writes 1
    always @(negedge clk) n_pulse += {frame_drop, 8'h00} + reg_wr_pulse;
    mbrw_master #(.RSP_TIMEOUT(200)) mbrw_master_inst (.clk, .rst, .link, .req_valid,
        .req_unit, .req_rd_reg, .req_rd_cnt, .req_wr_reg, .req_wr_cnt, .req_wr_data,
        .busy, .done, .ok, .exc_code, .timeout, .rd_data);
    mbrw_device mbrw_device_inst (.clk, .rst, .link, .unit_addr(8'h01), .reg_wr_pulse,
        .reg_wr_num, .reg_wr_val, .frame_drop);
    mbrw_link_chk mbrw_link_chk_inst (.clk, .rst, .q_data(link.q_data),
        .q_valid(link.q_valid), .q_last(link.q_last), .r_data(link.r_data),
        .r_valid(link.r_valid), .r_last(link.r_last));
    task automatic cmp(input logic [15:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request, then a bounded wait for done
    task automatic req(input logic [7:0] u, logic [15:0] rr, logic [4:0] rc,
        logic [15:0] wr, logic [4:0] wc, logic [31:0] wd);
        @(negedge clk);
        {req_valid, req_unit, req_rd_reg, req_rd_cnt} = {1'b1, u, rr, rc};
        {req_wr_reg, req_wr_cnt, req_wr_data} = {wr, wc, 224'h0, wd};
        @(negedge clk);
        req_valid = 1'b0;
        for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
        cmp({busy, 15'(done)}, 16'h1);
    endtask
    task automatic exc(input logic [15:0] rr, logic [4:0] rc, logic [15:0] wr,
        logic [4:0] wc, logic [31:0] wd, logic [7:0] code);
        req(8'h01, rr, rc, wr, wc, wd);
        cmp({ok, 7'h00, exc_code}, {code == EXC_NONE, 7'h00, code});
    endtask
    task automatic t_rw;
        req(8'h01, 16'h5, 5'h2, 16'h5, 5'h2, 32'h1388_0007);
        cmp({ok, 7'h00, exc_code}, 16'h8000);
        cmp(rd_data[15:0], 16'h7);
        cmp(rd_data[31:16], 16'h1388);
        cmp(reg_wr_num, 16'h6);
        cmp(reg_wr_val, 16'h1388);
    endtask
    task automatic t_exc;
        exc(16'h5, 5'h11, 16'h5, 5'h1, 32'h0, EXC_DATA);
        exc(16'h5, 5'h1, 16'h5, 5'h11, 32'h0, EXC_DATA);
        exc(16'h5, 5'h0, 16'h5, 5'h1, 32'h0, EXC_DATA);
        exc(16'h5, 5'h1, 16'h21, 5'h1, 32'h0, EXC_ADDR);
        exc(16'h5, 5'h1, 16'h19, 5'h1, 32'h0, EXC_RO);
        exc(16'h5, 5'h1, 16'h1, 5'h1, 32'h0, EXC_PAIR);
        exc(16'h5, 5'h1, 16'h5, 5'h2, 32'h1_2711, EXC_RANGE);
        exc(16'h5, 5'h2, 16'h2, 5'h1, 32'h0, EXC_NONE);
        cmp(rd_data[15:0], 16'h7);
        cmp(rd_data[31:16], 16'h1388);
    endtask
    task automatic t_bcast;
        req(8'h00, 16'h5, 5'h1, 16'h5, 5'h1, 32'h9);
        cmp(16'(ok), 16'h1);
        req(8'h02, 16'h5, 5'h1, 16'h5, 5'h1, 32'h9);
        cmp(16'(timeout), 16'h1);
        exc(16'h5, 5'h1, 16'h6, 5'h1, 32'h1388, EXC_NONE);
        cmp(rd_data[15:0], 16'h7);
        exc(16'h9, 5'h10, 16'h9, 5'h10, 32'h4, EXC_NONE);
        cmp(rd_data[15:0] | rd_data[255:240], 16'h4);
        cmp(16'(n_pulse), 16'h0214);
    endtask
    task automatic print_verdict;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // a hang is cut at 6000 cycles, well beyond the length of the whole run
    initial begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_rw();
        t_exc();
        t_bcast();
        print_verdict();
    end
endmodule

// File: design/mbrw_crc16.sv
// running crc-16 over a byte stream, reflected polynomial
`timescale 1ns/1ps
module mbrw_crc16 import mbrw_pkg::*; (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // byte stream
    input  wire logic        init,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc
);
    logic [15:0] crc_d;
    logic [15:0] c;

    always_comb begin
        c = crc ^ {8'h00, data};
        for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        crc_d = init ? CRC_INIT : (en ? c : crc);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            crc <= CRC_INIT;
        end else begin
            crc <= crc_d;
        end
    end
endmodule

// File: design/mbrw_device.sv
// responding device end: decodes function 17h, writes, then reads back
`timescale 1ns/1ps
// What this block does
// [RL1] query: address, 17h, read start, read count
// [RL2] then write start, count, byte count, data
// [RL3] start field is register number minus one
// [RL4] store write block, then return read block
// [RL5] reply: address, 17h, byte count, data, crc
// [RL6] byte counts are two per register
// [RL7] over sixteen registers gives exception 03h
// [RL8] answer own address; broadcast is ignored
// [RL9] errored query gets exception reply instead
// [RL10] exception reply: address, function, code, crc
// [RL11] exception function is query function plus 80h
// [RL12] unsupported function gives exception 01h
// [RL13] missing register gives exception 02h
// [RL14] bad data format gives exception 03h
// [RL15] write value out of range gives 21h
// [RL16] upper word alone of pair gives 27h
// [RL17] write to read-only register gives 23h
// [RL18] crc-16 checked; bad query silently dropped
module mbrw_device import mbrw_pkg::*; (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // link to master
    mbrw_link_if.slave       link,
    // own station address
    input  wire logic [7:0]  unit_addr,
    // register write report
    output logic             reg_wr_pulse,
    output logic      [15:0] reg_wr_num,
    output logic      [15:0] reg_wr_val,
    // dropped query report
    output logic             frame_drop
);
    // ========================================
    // state
    mbrw_dev_state_t st_q, st_d;
    logic [7:0]  rx_q   [RX_DEPTH];
    logic [7:0]  rx_d   [RX_DEPTH];
    logic [15:0] regs_q [NUM_REGS];
    logic [15:0] regs_d [NUM_REGS];
    logic [7:0]  len_q, len_d;
    logic [7:0]  exc_q, exc_d;
    logic [3:0]  wi_q, wi_d;
    logic [5:0]  ti_q, ti_d;
    logic [7:0]  txd_q, txd_d;
    logic        txv_q, txv_d;
    logic        txl_q, txl_d;
    logic        wrp_q, wrp_d;
    logic [15:0] wrn_q, wrn_d;
    logic [15:0] wrv_q, wrv_d;
    logic        drop_q, drop_d;
    logic        crc_init, crc_en;
    logic [7:0]  crc_byte;
    logic [15:0] crc_val;

    // ========================================
    // query fields
    logic [15:0] rs, rc, ws, wc;
    logic [7:0]  bc;
    logic [16:0] rd_last, wr_last;
    logic        fmt_bad, addr_bad, ro_bad, rng_bad, pair_bad;
    logic [7:0]  exc_eval;
    logic [15:0] wnum, wval;

    assign rs = {rx_q[OFS_RS], rx_q[OFS_RS+1]};    // [RL1]
    assign rc = {rx_q[OFS_RC], rx_q[OFS_RC+1]};    // [RL1]
    assign ws = {rx_q[OFS_WS], rx_q[OFS_WS+1]};    // [RL2]
    assign wc = {rx_q[OFS_WC], rx_q[OFS_WC+1]};    // [RL2]
    assign bc = rx_q[OFS_BC];                      // [RL2]
    // last register number = start field + count, since the field is one below
    assign rd_last = {1'b0, rs} + {1'b0, rc};      // [RL3]
    assign wr_last = {1'b0, ws} + {1'b0, wc};      // [RL3]

    always_comb begin
        fmt_bad = (rc == 16'h0000) || (rc > MAX_REGS)       // [RL7]
               || (wc == 16'h0000) || (wc > MAX_REGS)       // [RL7]
               || (bc != {wc[6:0], 1'b0})                   // [RL6]
               || (len_q != FRAME_OVH + bc);                // [RL14]
        addr_bad = (rd_last > NUM_REGS_17) || (wr_last > NUM_REGS_17);   // [RL13]
        // a block that ends on the upper word holds it without its lower word
        pair_bad = (rd_last == PAIR_HI) || (wr_last == PAIR_HI);        // [RL16]
        ro_bad  = 1'b0;
        rng_bad = 1'b0;
        for (int i = 0; i < 16; i++) begin
            wnum = ws + 16'(i + 1);
            wval = {rx_q[11 + 2 * i], rx_q[12 + 2 * i]};
            if (16'(i) < wc) begin
                if (wnum >= REG_RO_FIRST) ro_bad = 1'b1;     // [RL17]
                if (wval > REG_VAL_MAX) rng_bad = 1'b1;     // [RL15]
            end
        end
        if (rx_q[OFS_FUNC] != FC_RW) exc_eval = EXC_FUNC;   // [RL12]
        else if (fmt_bad) exc_eval = EXC_DATA;              // [RL7] [RL14]
        else if (addr_bad) exc_eval = EXC_ADDR;             // [RL13]
        else if (ro_bad) exc_eval = EXC_RO;                 // [RL17]
        else if (pair_bad) exc_eval = EXC_PAIR;             // [RL16]
        else if (rng_bad) exc_eval = EXC_RANGE;             // [RL15]
        else exc_eval = EXC_NONE;
    end

    // ========================================
    // reply byte selection
    logic [5:0]  n_tx, j;
    logic [7:0]  tx_byte;
    logic [15:0] rword;

    always_comb begin
        n_tx  = (exc_q != EXC_NONE) ? 6'd5 : 6'(5 + 2 * rc[4:0]);  // [RL5] [RL10]
        j     = ti_q - 6'd3;
        rword = regs_q[5'(rs + 16'(j[5:1]))];                      // [RL3]
        if (ti_q == 6'd0) tx_byte = rx_q[OFS_ADDR];
        else if (ti_q == 6'd1) tx_byte = (exc_q != EXC_NONE)
                                          ? (rx_q[OFS_FUNC] | FC_EXC)    // [RL11]
                                          : FC_RW;                       // [RL5]
        else if (ti_q == 6'd2) tx_byte = (exc_q != EXC_NONE)
                                          ? exc_q                        // [RL10]
                                          : {rc[6:0], 1'b0};             // [RL6]
        else if (ti_q == n_tx - 6'd2) tx_byte = crc_val[7:0];            // [RL18]
        else if (ti_q == n_tx - 6'd1) tx_byte = crc_val[15:8];           // [RL18]
        else tx_byte = j[0] ? rword[7:0] : rword[15:8];                  // [RL5]
    end

    // ========================================
    // sequencing
    always_comb begin
        st_d   = st_q;
        rx_d   = rx_q;
        regs_d = regs_q;
        len_d  = len_q;
        exc_d  = exc_q;
        wi_d   = wi_q;
        ti_d   = ti_q;
        txd_d  = 8'h00;
        txv_d  = 1'b0;
        txl_d  = 1'b0;
        wrp_d  = 1'b0;
        wrn_d  = wrn_q;
        wrv_d  = wrv_q;
        drop_d = 1'b0;
        crc_init = 1'b0;
        crc_en   = 1'b0;
        crc_byte = link.q_data;
        case (st_q)
            DS_RX: begin
                // half duplex: bytes arriving while replying are not taken
                if (link.q_valid) begin
                    if (len_q < 8'(RX_DEPTH)) rx_d[len_q[5:0]] = link.q_data;
                    if (len_q != 8'hff) len_d = len_q + 8'h01;
                    crc_en = 1'b1;                                       // [RL18]
                    if (link.q_last) st_d = DS_EVAL;
                end
            end
            DS_EVAL: begin
                crc_init = 1'b1;
                len_d = 8'h00;
                ti_d  = 6'd0;
                wi_d  = 4'd0;
                exc_d = exc_eval;                                        // [RL9]
                if (len_q < MIN_LEN || crc_val != 16'h0000) begin        // [RL18]
                    st_d   = DS_RX;
                    drop_d = 1'b1;
                end else if (rx_q[OFS_ADDR] == BCAST_ADDR
                             || rx_q[OFS_ADDR] != unit_addr) begin       // [RL8]
                    st_d   = DS_RX;
                    drop_d = 1'b1;
                end else if (exc_eval == EXC_NONE) begin
                    st_d = DS_WR;                                        // [RL4]
                end else begin
                    st_d = DS_TX;                                        // [RL9]
                end
            end
            DS_WR: begin
                // whole block checked before the first word lands
                regs_d[5'(ws + 16'(wi_q))] = {rx_d[OFS_WDATA + {1'b0, wi_q, 1'b0}],
                                              rx_d[OFS_WDATA + {1'b0, wi_q, 1'b1}]};  // [RL4]
                wrp_d = 1'b1;
                wrn_d = ws + 16'(wi_q) + 16'h0001;                       // [RL3]
                wrv_d = regs_d[5'(ws + 16'(wi_q))];
                wi_d  = wi_q + 4'd1;
                if (wi_q == 4'(wc - 16'h0001)) st_d = DS_TX;             // [RL4]
            end
            DS_TX: begin
                txd_d = tx_byte;
                txv_d = 1'b1;
                crc_byte = tx_byte;
                crc_en = (ti_q < n_tx - 6'd2);                           // [RL18]
                ti_d = ti_q + 6'd1;
                if (ti_q == n_tx - 6'd1) begin
                    txl_d = 1'b1;
                    crc_init = 1'b1;
                    st_d = DS_RX;
                end
            end
            default: begin
                st_d = DS_RX;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= DS_RX;
            len_q  <= 8'h00;
            exc_q  <= EXC_NONE;
            wi_q   <= 4'd0;
            ti_q   <= 6'd0;
            txd_q  <= 8'h00;
            txv_q  <= 1'b0;
            txl_q  <= 1'b0;
            wrp_q  <= 1'b0;
            wrn_q  <= 16'h0000;
            wrv_q  <= 16'h0000;
            drop_q <= 1'b0;
            for (int i = 0; i < RX_DEPTH; i++) rx_q[i] <= 8'h00;
            for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= REG_RST_VAL;
        end else begin
            st_q   <= st_d;
            len_q  <= len_d;
            exc_q  <= exc_d;
            wi_q   <= wi_d;
            ti_q   <= ti_d;
            txd_q  <= txd_d;
            txv_q  <= txv_d;
            txl_q  <= txl_d;
            wrp_q  <= wrp_d;
            wrn_q  <= wrn_d;
            wrv_q  <= wrv_d;
            drop_q <= drop_d;
            rx_q   <= rx_d;
            regs_q <= regs_d;
        end
    end

    mbrw_crc16 u_crc (
        .clk  (clk),
        .rst  (rst),
        .init (crc_init),
        .en   (crc_en),
        .data (crc_byte),
        .crc  (crc_val)
    );

    assign link.r_data  = txd_q;
    assign link.r_valid = txv_q;
    assign link.r_last  = txl_q;
    assign reg_wr_pulse = wrp_q;
    assign reg_wr_num   = wrn_q;
    assign reg_wr_val   = wrv_q;
    assign frame_drop   = drop_q;
endmodule

// File: design/mbrw_link_if.sv
// byte link between the master and the responding device
`timescale 1ns/1ps
interface mbrw_link_if;
    // master to device query bytes
    logic [7:0] q_data;
    logic       q_valid;
    logic       q_last;
    // device to master reply bytes
    logic [7:0] r_data;
    logic       r_valid;
    logic       r_last;
    modport master (output q_data, q_valid, q_last, input r_data, r_valid, r_last);
    modport slave  (input q_data, q_valid, q_last, output r_data, r_valid, r_last);
endinterface

// File: design/mbrw_master.sv
// master end: builds function 17h queries and collects the reply
`timescale 1ns/1ps
module mbrw_master import mbrw_pkg::*; #(
    parameter int RSP_TIMEOUT = RSP_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // link to device
    mbrw_link_if.master       link,
    // request
    input  wire logic         req_valid,
    input  wire logic [7:0]   req_unit,
    input  wire logic [15:0]  req_rd_reg,
    input  wire logic [4:0]   req_rd_cnt,
    input  wire logic [15:0]  req_wr_reg,
    input  wire logic [4:0]   req_wr_cnt,
    input  wire logic [255:0] req_wr_data,
    // result
    output logic              busy,
    output logic              done,
    output logic              ok,
    output logic      [7:0]   exc_code,
    output logic              timeout,
    output logic      [255:0] rd_data
);
    // ========================================
    // state
    mbrw_host_state_t st_q, st_d;
    logic [7:0]   unit_q, unit_d;
    logic [15:0]  rs_q, rs_d, ws_q, ws_d;
    logic [4:0]   rc_q, rc_d, wc_q, wc_d;
    logic [255:0] wd_q, wd_d, rd_q, rd_d;
    logic [7:0]   ti_q, ti_d;
    logic [7:0]   hdr0_q, hdr0_d, hdr1_q, hdr1_d, hdr2_q, hdr2_d;
    logic [19:0]  tmo_q, tmo_d;
    logic [7:0]   qd_q, qd_d;
    logic         qv_q, qv_d, ql_q, ql_d;
    logic         done_q, done_d, ok_q, ok_d, to_q, to_d;
    logic [7:0]   exc_q, exc_d;
    logic         crc_init, crc_en;
    logic [7:0]   crc_byte, tx_byte, bc, n_tx, j, rj;
    logic [15:0]  crc_val;

    // ========================================
    // query byte selection
    always_comb begin
        bc   = {2'b00, wc_q, 1'b0};                     // [RL6]
        n_tx = FRAME_OVH + bc;
        j    = ti_q - 8'(OFS_WDATA);
        case (ti_q)
            8'd0: tx_byte = unit_q;                     // [RL1]
            8'd1: tx_byte = FC_RW;                      // [RL1]
            8'd2: tx_byte = rs_q[15:8];                 // [RL1]
            8'd3: tx_byte = rs_q[7:0];
            8'd4: tx_byte = 8'h00;
            8'd5: tx_byte = {3'b000, rc_q};
            8'd6: tx_byte = ws_q[15:8];                 // [RL2]
            8'd7: tx_byte = ws_q[7:0];
            8'd8: tx_byte = 8'h00;
            8'd9: tx_byte = {3'b000, wc_q};
            8'd10: tx_byte = bc;                        // [RL2]
            default: begin
                if (ti_q == n_tx - 8'd2) tx_byte = crc_val[7:0];        // [RL18]
                else if (ti_q == n_tx - 8'd1) tx_byte = crc_val[15:8];  // [RL18]
                else tx_byte = wd_q[{j[4:1], ~j[0], 3'b000} +: 8];      // [RL2]
            end
        endcase
    end

    // ========================================
    // sequencing
    always_comb begin
        st_d = st_q;
        unit_d = unit_q;
        rs_d = rs_q;
        ws_d = ws_q;
        rc_d = rc_q;
        wc_d = wc_q;
        wd_d = wd_q;
        rd_d = rd_q;
        ti_d = ti_q;
        hdr0_d = hdr0_q;
        hdr1_d = hdr1_q;
        hdr2_d = hdr2_q;
        tmo_d = tmo_q;
        qd_d = 8'h00;
        qv_d = 1'b0;
        ql_d = 1'b0;
        done_d = 1'b0;
        ok_d = ok_q;
        to_d = to_q;
        exc_d = exc_q;
        crc_init = 1'b0;
        crc_en = 1'b0;
        crc_byte = link.r_data;
        rj = ti_q - 8'd3;
        case (st_q)
            HS_IDLE: begin
                crc_init = 1'b1;
                ti_d = 8'h00;
                if (req_valid) begin
                    unit_d = req_unit;
                    rs_d = req_rd_reg - 16'h0001;       // [RL3]
                    ws_d = req_wr_reg - 16'h0001;       // [RL3]
                    rc_d = req_rd_cnt;
                    wc_d = req_wr_cnt;
                    wd_d = req_wr_data;
                    ok_d = 1'b0;
                    to_d = 1'b0;
                    exc_d = EXC_NONE;
                    st_d = HS_SEND;
                end
            end
            HS_SEND: begin
                qd_d = tx_byte;
                qv_d = 1'b1;
                crc_byte = tx_byte;
                crc_en = (ti_q < n_tx - 8'd2);          // [RL18]
                ti_d = ti_q + 8'h01;
                if (ti_q == n_tx - 8'd1) begin
                    ql_d = 1'b1;
                    crc_init = 1'b1;
                    ti_d = 8'h00;
                    tmo_d = 20'h0_0000;
                    // a broadcast is never answered, so finish at once
                    if (unit_q == BCAST_ADDR) begin
                        st_d = HS_IDLE;
                        done_d = 1'b1;
                        ok_d = 1'b1;
                    end else begin
                        st_d = HS_WAIT;
                    end
                end
            end
            HS_WAIT, HS_CHK: begin
                tmo_d = tmo_q + 20'h0_0001;
                if (st_q == HS_WAIT && link.r_valid) begin
                    crc_en = 1'b1;                      // [RL18]
                    if (ti_q != 8'hff) ti_d = ti_q + 8'h01;
                    if (ti_q == 8'd0) hdr0_d = link.r_data;
                    if (ti_q == 8'd1) hdr1_d = link.r_data;
                    if (ti_q == 8'd2) hdr2_d = link.r_data;
                    if (ti_q >= 8'd3 && ti_q < 8'd35) begin
                        rd_d[{rj[4:1], ~rj[0], 3'b000} +: 8] = link.r_data;
                    end
                    if (link.r_last) st_d = HS_CHK;
                end
                if (st_q == HS_CHK) begin
                    crc_init = 1'b1;
                    ti_d = 8'h00;
                    st_d = HS_WAIT;
                    // a corrupt or foreign reply is ignored and the wait goes on
                    if (crc_val == 16'h0000 && hdr0_q == unit_q) begin   // [RL18]
                        if (hdr1_q == FC_RW) begin
                            st_d = HS_IDLE;
                            done_d = 1'b1;
                            ok_d = 1'b1;
                        end else if (hdr1_q == (FC_RW | FC_EXC)) begin
                            st_d = HS_IDLE;
                            done_d = 1'b1;
                            exc_d = hdr2_q;
                        end
                    end
                end
                if (tmo_q >= 20'(RSP_TIMEOUT - 1) && st_d != HS_IDLE) begin
                    st_d = HS_IDLE;
                    done_d = 1'b1;
                    to_d = 1'b1;
                end
            end
            default: begin
                st_d = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= HS_IDLE;
            unit_q <= 8'h00;
            rs_q <= 16'h0000;
            ws_q <= 16'h0000;
            rc_q <= 5'd0;
            wc_q <= 5'd0;
            wd_q <= '0;
            rd_q <= '0;
            ti_q <= 8'h00;
            hdr0_q <= 8'h00;
            hdr1_q <= 8'h00;
            hdr2_q <= 8'h00;
            tmo_q <= 20'h0_0000;
            qd_q <= 8'h00;
            qv_q <= 1'b0;
            ql_q <= 1'b0;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            to_q <= 1'b0;
            exc_q <= EXC_NONE;
        end else begin
            st_q <= st_d;
            unit_q <= unit_d;
            rs_q <= rs_d;
            ws_q <= ws_d;
            rc_q <= rc_d;
            wc_q <= wc_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            ti_q <= ti_d;
            hdr0_q <= hdr0_d;
            hdr1_q <= hdr1_d;
            hdr2_q <= hdr2_d;
            tmo_q <= tmo_d;
            qd_q <= qd_d;
            qv_q <= qv_d;
            ql_q <= ql_d;
            done_q <= done_d;
            ok_q <= ok_d;
            to_q <= to_d;
            exc_q <= exc_d;
        end
    end

    mbrw_crc16 u_crc (
        .clk  (clk),
        .rst  (rst),
        .init (crc_init),
        .en   (crc_en),
        .data (crc_byte),
        .crc  (crc_val)
    );

    assign link.q_data  = qd_q;
    assign link.q_valid = qv_q;
    assign link.q_last  = ql_q;
    assign busy     = (st_q != HS_IDLE);
    assign done     = done_q;
    assign ok       = ok_q;
    assign exc_code = exc_q;
    assign timeout  = to_q;
    assign rd_data  = rd_q;
endmodule

// File: design/mbrw_pkg.sv
// shared constants and state types for the read/write register link
package mbrw_pkg;
    // ========================================
    // function and exception codes
    localparam logic [7:0] FC_RW      = 8'h17;
    localparam logic [7:0] FC_EXC     = 8'h80;
    localparam logic [7:0] EXC_NONE   = 8'h00;
    localparam logic [7:0] EXC_FUNC   = 8'h01;
    localparam logic [7:0] EXC_ADDR   = 8'h02;
    localparam logic [7:0] EXC_DATA   = 8'h03;
    localparam logic [7:0] EXC_RANGE  = 8'h21;
    localparam logic [7:0] EXC_RO     = 8'h23;
    localparam logic [7:0] EXC_PAIR   = 8'h27;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    // ========================================
    // query byte offsets
    localparam int OFS_ADDR  = 0;
    localparam int OFS_FUNC  = 1;
    localparam int OFS_RS    = 2;
    localparam int OFS_RC    = 4;
    localparam int OFS_WS    = 6;
    localparam int OFS_WC    = 8;
    localparam int OFS_BC    = 10;
    localparam logic [5:0] OFS_WDATA = 6'h0b;
    localparam logic [7:0] FRAME_OVH = 8'h0d;
    localparam logic [7:0] MIN_LEN   = 8'h04;
    localparam int RX_DEPTH  = 48;
    // ========================================
    // register map of the device
    localparam int NUM_REGS              = 32;
    localparam logic [16:0] NUM_REGS_17  = 17'h0_0020;
    localparam logic [15:0] MAX_REGS     = 16'h0010;
    localparam logic [15:0] REG_RO_FIRST = 16'h0019;
    localparam logic [16:0] PAIR_HI      = 17'h0_0001;
    localparam logic [15:0] REG_VAL_MAX  = 16'h2710;
    localparam logic [15:0] REG_RST_VAL  = 16'h0000;
    // ========================================
    // check sequence and timing
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam int CLK_HZ         = 50_000_000;
    localparam int RSP_TIMEOUT_US = 1000;
    localparam int RSP_TIMEOUT_CYC = CLK_HZ / 1_000_000 * RSP_TIMEOUT_US;
    // ========================================
    // state machines
    typedef enum logic [1:0] {
        DS_RX   = 2'b00,
        DS_EVAL = 2'b01,
        DS_WR   = 2'b10,
        DS_TX   = 2'b11
    } mbrw_dev_state_t;
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_SEND = 2'b01,
        HS_WAIT = 2'b10,
        HS_CHK  = 2'b11
    } mbrw_host_state_t;
endpackage
